// ===== rtl/cfr_pkg.sv
// Constants, register map and state encodings of the clock fanout configuration bank.
package cfr_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  localparam logic [6:0] ADDR_AMP_GAIN  = 7'h00;
  localparam logic [6:0] ADDR_DAMPING   = 7'h01;
  localparam logic [6:0] ADDR_LOAD_CAP  = 7'h02;
  localparam logic [6:0] ADDR_RUN_POL   = 7'h03;
  localparam logic [6:0] ADDR_REF_SEL   = 7'h05;
  localparam logic [6:0] ADDR_PULL_LOW  = 7'h06;
  localparam logic [6:0] ADDR_STD_A     = 7'h07;
  localparam logic [6:0] ADDR_STD_B     = 7'h09;
  localparam logic [6:0] ADDR_SE_DIV    = 7'h0b;
  localparam logic [6:0] ADDR_SE_ON     = 7'h0c;
  localparam logic [6:0] ADDR_SE_DRIVE  = 7'h0d;
  localparam logic [6:0] ADDR_PART_ID   = 7'h11;

  localparam logic [7:0] RST_AMP_GAIN   = 8'hff;
  localparam logic [7:0] RST_DAMPING    = 8'h04;
  localparam logic [7:0] RST_LOAD_CAP   = 8'h40;
  localparam logic       RST_RUN_POL    = 1'b1;
  localparam logic [1:0] RST_REF_SEL    = 2'h0;
  localparam logic       RST_PULL_LOW   = 1'b0;
  localparam logic [3:0] RST_STD_A      = 4'hf;
  localparam logic [5:0] RST_STD_B      = 6'h3f;
  localparam logic [2:0] RST_SE_DIV     = 3'h0;
  localparam logic       RST_SE_ON      = 1'b0;
  localparam logic       RST_SE_DRIVE   = 1'b0;

  // Fixed read values of reserved fields and of unused addresses.
  localparam logic [6:0] RSV_ONES7      = 7'h7f;
  localparam logic [5:0] RSV_ONES6      = 6'h3f;
  localparam logic [4:0] RSV_ONES5      = 5'h1f;
  localparam logic [1:0] RSV_ID_MID     = 2'h3;
  localparam logic [7:0] READ_NONE      = 8'h00;

  localparam logic [1:0] REF_IN0        = 2'h0;
  localparam logic [1:0] REF_IN1        = 2'h1;
  localparam logic [1:0] REF_CRYSTAL    = 2'h2;
  localparam logic [1:0] REF_BYPASS     = 2'h3;

  localparam logic [1:0] STD_LVPECL     = 2'h0;
  localparam logic [1:0] STD_LVDS       = 2'h1;
  localparam logic [1:0] STD_HCSL       = 2'h2;
  localparam logic [1:0] STD_OFF        = 2'h3;

  localparam int unsigned N_DIFF        = 5;
  localparam int unsigned N_STAGE       = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMD  = 3'b010,
    ST_DATA = 3'b100
  } cfr_state_e;

endpackage

// ===== rtl/cfr_shift.sv
// Serial bit engine: gathers received bytes and presents transmit bits in either order.
`timescale 1ns/1ns
`default_nettype none
module cfr_shift (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Serial strobes, already synchronised
  input  wire logic       clear,
  input  wire logic       sck_rise,
  input  wire logic       sck_fall,
  input  wire logic       sdi,
  input  wire logic       lsb_first,
  // Transmit byte load
  input  wire logic       load,
  input  wire logic [7:0] load_byte,
  // Receive side and transmit bit
  output logic            byte_done,
  output logic [7:0]      rx_byte,
  output logic            sdo
);

  logic [2:0] cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic       done_q;
  logic       sdo_q;

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      cnt_q <= 3'h0;
    end else if (sck_rise) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_q   <= 8'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= sck_rise && !clear && (cnt_q == 3'h7);
      if (sck_rise && !clear) begin
        rx_q <= lsb_first ? {sdi, rx_q[7:1]} : {rx_q[6:0], sdi};
      end
    end
  end

  // The byte stays static; the bit counter picks the lane, so no second shifter is needed.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_q  <= 8'h00;
      sdo_q <= 1'b0;
    end else if (load) begin
      tx_q  <= load_byte;
      sdo_q <= lsb_first ? load_byte[0] : load_byte[7];
    end else if (sck_fall && cnt_q != 3'h0) begin
      sdo_q <= lsb_first ? tx_q[cnt_q] : tx_q[3'h7 - cnt_q];
    end
  end

  assign byte_done = done_q;
  assign rx_byte   = rx_q;
  assign sdo       = sdo_q;

endmodule // cfr_shift
`default_nettype wire

// ===== rtl/cfr_regs.sv
// Configuration register bank with its serial slave port and the decoded analog controls.
`timescale 1ns/1ns
`default_nettype none
module cfr_regs #(
  parameter logic [4:0] PART_ID = 5'h0a  // Arbitrary neutral value.
) (
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  // Serial port pins
  input  wire logic       SCK,
  input  wire logic       CS_N,
  input  wire logic       SI,
  output logic            SO,
  output logic            SO_OE,
  // Crystal oscillator controls
  output logic [3:0]      XTAL_GAIN_STAGES,
  output logic [5:0]      XTAL_DAMP_SEL,
  output logic [7:0]      XTAL_CAP_SEL,
  output logic            XTAL_AMP_ON,
  // Reference and differential outputs
  output logic [1:0]      REF_SEL,
  output logic [9:0]      DIFF_STD,
  output logic [4:0]      DIFF_ON,
  output logic [4:0]      DIFF_IDLE_LOW,
  // Single-ended output
  output logic [3:0]      SE_DIV_RATIO,
  output logic            SE_ON,
  output logic            SE_IDLE_LOW,
  output logic            SE_DRIVE_HIGH
);

  // The field packing below is fixed, so other output or stage counts are refused at elaboration.
  if (cfr_pkg::N_DIFF != 5 || cfr_pkg::N_STAGE != 4) begin : g_layout_bad
    $error("Register layout serves exactly five outputs and four gain stages.");
  end

  // Pin synchronisers; first stage feeds only the second.
  logic sck_s1, sck_s2, sck_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic si_s1, si_s2;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_s3  <= 1'b1;
      si_s1  <= 1'b0;
      si_s2  <= 1'b0;
    end else begin
      sck_s1 <= SCK;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      cs_s1  <= CS_N;
      cs_s2  <= cs_s1;
      cs_s3  <= cs_s2;
      si_s1  <= SI;
      si_s2  <= si_s1;
    end
  end

  logic sck_rise, sck_fall, cs_start, cs_off;
  assign sck_rise = sck_s2 && !sck_s3;
  assign sck_fall = !sck_s2 && sck_s3;
  assign cs_start = !cs_s2 && cs_s3;
  assign cs_off   = cs_s2;

  // Register fields.
  logic [7:0] gain_q, damp_q, cap_q;
  logic       run_pol_q, pull_low_q, se_on_q, se_drv_q;
  logic [1:0] ref_q;
  logic [3:0] std_a_q;
  logic [5:0] std_b_q;
  logic [2:0] div_q;

  function automatic logic [7:0] reg_read(input logic [6:0] a);
    logic [7:0] v;
    v = cfr_pkg::READ_NONE;
    if (a == cfr_pkg::ADDR_AMP_GAIN) begin
      v = gain_q;
    end else if (a == cfr_pkg::ADDR_DAMPING) begin
      v = damp_q;
    end else if (a == cfr_pkg::ADDR_LOAD_CAP) begin
      v = cap_q;
    end else if (a == cfr_pkg::ADDR_RUN_POL) begin
      v = {cfr_pkg::RSV_ONES7, run_pol_q};
    end else if (a == cfr_pkg::ADDR_REF_SEL) begin
      v = {cfr_pkg::RSV_ONES6, ref_q};
    end else if (a == cfr_pkg::ADDR_PULL_LOW) begin
      v = {cfr_pkg::RSV_ONES7, pull_low_q};
    end else if (a == cfr_pkg::ADDR_STD_A) begin
      v = {std_a_q, 4'h0};
    end else if (a == cfr_pkg::ADDR_STD_B) begin
      v = {std_b_q, 2'h0};
    end else if (a == cfr_pkg::ADDR_SE_DIV) begin
      v = {cfr_pkg::RSV_ONES5, div_q};
    end else if (a == cfr_pkg::ADDR_SE_ON) begin
      v = {cfr_pkg::RSV_ONES7, se_on_q};
    end else if (a == cfr_pkg::ADDR_SE_DRIVE) begin
      v = {cfr_pkg::RSV_ONES7, se_drv_q};
    end else if (a == cfr_pkg::ADDR_PART_ID) begin
      v = {1'b0, cfr_pkg::RSV_ID_MID, PART_ID};
    end
    return v;
  endfunction

  // Serial engine.
  logic       byte_done, sdo, load;
  logic [7:0] rx_byte, load_byte;
  logic       lsb_q, rw_q;
  logic [6:0] addr_q;
  cfr_pkg::cfr_state_e state_q;

  cfr_shift u_shift (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .clear     (cs_off),
    .sck_rise  (sck_rise),
    .sck_fall  (sck_fall),
    .sdi       (si_s2),
    .lsb_first (lsb_q),
    .load      (load),
    .load_byte (load_byte),
    .byte_done (byte_done),
    .rx_byte   (rx_byte),
    .sdo       (sdo)
  );

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      lsb_q <= 1'b0;
    end else if (cs_start) begin
      lsb_q <= sck_s2;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N || cs_off) begin
      state_q <= cfr_pkg::ST_IDLE;
      rw_q    <= 1'b0;
      addr_q  <= 7'h00;
    end else begin
      case (state_q)
        cfr_pkg::ST_IDLE: begin
          state_q <= cfr_pkg::ST_CMD;
        end
        cfr_pkg::ST_CMD: begin
          if (byte_done) begin
            rw_q    <= rx_byte[7];
            addr_q  <= rx_byte[6:0];
            state_q <= cfr_pkg::ST_DATA;
          end
        end
        cfr_pkg::ST_DATA: begin
          if (byte_done) begin
            addr_q <= addr_q + 7'h01;
          end
        end
        default: state_q <= cfr_pkg::ST_IDLE;
      endcase
    end
  end

  // Read data for the next byte is loaded right after the previous byte ends.
  logic       load_q;
  logic [7:0] load_byte_q;
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      load_q      <= 1'b0;
      load_byte_q <= 8'h00;
    end else begin
      load_q <= 1'b0;
      if (!cs_off && byte_done && state_q == cfr_pkg::ST_CMD && rx_byte[7]) begin
        load_q      <= 1'b1;
        load_byte_q <= reg_read(rx_byte[6:0]);
      end else if (!cs_off && byte_done && state_q == cfr_pkg::ST_DATA && rw_q) begin
        load_q      <= 1'b1;
        load_byte_q <= reg_read(addr_q + 7'h01);
      end
    end
  end
  assign load      = load_q;
  assign load_byte = load_byte_q;

  logic wr_en;
  assign wr_en = !cs_off && byte_done && state_q == cfr_pkg::ST_DATA && !rw_q;

  // Only defined fields take writes; reserved bits and unused addresses are ignored.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      gain_q     <= cfr_pkg::RST_AMP_GAIN;
      damp_q     <= cfr_pkg::RST_DAMPING;
      cap_q      <= cfr_pkg::RST_LOAD_CAP;
      run_pol_q  <= cfr_pkg::RST_RUN_POL;
      ref_q      <= cfr_pkg::RST_REF_SEL;
      pull_low_q <= cfr_pkg::RST_PULL_LOW;
      std_a_q    <= cfr_pkg::RST_STD_A;
      std_b_q    <= cfr_pkg::RST_STD_B;
      div_q      <= cfr_pkg::RST_SE_DIV;
      se_on_q    <= cfr_pkg::RST_SE_ON;
      se_drv_q   <= cfr_pkg::RST_SE_DRIVE;
    end else if (wr_en) begin
      if (addr_q == cfr_pkg::ADDR_AMP_GAIN) begin
        gain_q <= rx_byte;
      end else if (addr_q == cfr_pkg::ADDR_DAMPING) begin
        damp_q <= rx_byte;
      end else if (addr_q == cfr_pkg::ADDR_LOAD_CAP) begin
        cap_q <= rx_byte;
      end else if (addr_q == cfr_pkg::ADDR_RUN_POL) begin
        run_pol_q <= rx_byte[0];
      end else if (addr_q == cfr_pkg::ADDR_REF_SEL) begin
        ref_q <= rx_byte[1:0];
      end else if (addr_q == cfr_pkg::ADDR_PULL_LOW) begin
        pull_low_q <= rx_byte[0];
      end else if (addr_q == cfr_pkg::ADDR_STD_A) begin
        std_a_q <= rx_byte[7:4];
      end else if (addr_q == cfr_pkg::ADDR_STD_B) begin
        std_b_q <= rx_byte[7:2];
      end else if (addr_q == cfr_pkg::ADDR_SE_DIV) begin
        div_q <= rx_byte[2:0];
      end else if (addr_q == cfr_pkg::ADDR_SE_ON) begin
        se_on_q <= rx_byte[0];
      end else if (addr_q == cfr_pkg::ADDR_SE_DRIVE) begin
        se_drv_q <= rx_byte[0];
      end
    end
  end

  // Decoded controls, all registered.
  logic [9:0] std_all;
  assign std_all = {std_b_q, std_a_q};

  genvar g;
  generate
    for (g = 0; g < cfr_pkg::N_STAGE; g++) begin : g_stage
      always_ff @(posedge MCLK) begin
        if (!RST_N) begin
          XTAL_GAIN_STAGES[g] <= 1'b1;
        end else begin
          XTAL_GAIN_STAGES[g] <= &gain_q[2*g+1 -: 2];
        end
      end
    end
    for (g = 0; g < cfr_pkg::N_DIFF; g++) begin : g_diff
      always_ff @(posedge MCLK) begin
        if (!RST_N) begin
          DIFF_STD[2*g+1 -: 2] <= cfr_pkg::STD_OFF;
          DIFF_ON[g]           <= 1'b0;
          DIFF_IDLE_LOW[g]     <= 1'b0;
        end else begin
          DIFF_STD[2*g+1 -: 2] <= std_all[2*g+1 -: 2];
          DIFF_ON[g]           <= std_all[2*g+1 -: 2] != cfr_pkg::STD_OFF;
          DIFF_IDLE_LOW[g]     <= std_all[2*g+1 -: 2] == cfr_pkg::STD_OFF && pull_low_q;
        end
      end
    end
  endgenerate

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      XTAL_DAMP_SEL <= 6'h00;
      XTAL_CAP_SEL  <= 8'h00;
      XTAL_AMP_ON   <= 1'b0;
      REF_SEL       <= cfr_pkg::REF_IN0;
    end else begin
      XTAL_DAMP_SEL <= damp_q[6:1];
      XTAL_CAP_SEL  <= cap_q;
      XTAL_AMP_ON   <= (ref_q == cfr_pkg::REF_CRYSTAL) || !run_pol_q;
      REF_SEL       <= ref_q;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SE_DIV_RATIO  <= 4'h1;
      SE_ON         <= 1'b0;
      SE_IDLE_LOW   <= 1'b0;
      SE_DRIVE_HIGH <= 1'b0;
    end else begin
      SE_DIV_RATIO  <= {1'b0, div_q} + 4'h1;
      SE_ON         <= se_on_q;
      SE_IDLE_LOW   <= !se_on_q && pull_low_q;
      SE_DRIVE_HIGH <= se_drv_q;
    end
  end

  // The data pin is driven only during the data phase of a read.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SO_OE <= 1'b0;
    end else begin
      SO_OE <= !cs_off && state_q == cfr_pkg::ST_DATA && rw_q;
    end
  end
  assign SO = sdo;

  chk_amp_policy: assert property (@(posedge MCLK) disable iff (!RST_N)
    XTAL_AMP_ON == ($past(ref_q) == cfr_pkg::REF_CRYSTAL || !$past(run_pol_q)))
    else $error("Crystal amplifier state disagrees with run policy.");
  chk_gain_pairs: assert property (@(posedge MCLK) disable iff (!RST_N)
    $past(gain_q) == 8'hff |-> XTAL_GAIN_STAGES == 4'hf)
    else $error("Full gain code did not enable all stages.");
  chk_idle_low: assert property (@(posedge MCLK) disable iff (!RST_N)
    DIFF_IDLE_LOW[0] |-> $past(pull_low_q) && DIFF_STD[1:0] == cfr_pkg::STD_OFF)
    else $error("Output pulled low while not idle or pull disabled.");
  chk_se_idle: assert property (@(posedge MCLK) disable iff (!RST_N)
    SE_IDLE_LOW |-> !SE_ON)
    else $error("Single-ended output pulled low while enabled.");
  chk_div_ratio: assert property (@(posedge MCLK) disable iff (!RST_N)
    SE_DIV_RATIO == {1'b0, $past(div_q)} + 4'h1)
    else $error("Divider ratio is not field plus one.");
  chk_burst_incr: assert property (@(posedge MCLK) disable iff (!RST_N)
    byte_done && state_q == cfr_pkg::ST_DATA && !cs_off |=> addr_q == $past(addr_q) + 7'h01)
    else $error("Burst address did not advance.");
  chk_order_latch: assert property (@(posedge MCLK) disable iff (!RST_N)
    cs_start |=> lsb_q == $past(sck_s2))
    else $error("Bit order not taken from clock level at select.");
  chk_cmd_decode: assert property (@(posedge MCLK) disable iff (!RST_N)
    byte_done && state_q == cfr_pkg::ST_CMD && !cs_off |=> rw_q == $past(rx_byte[7]) && state_q == cfr_pkg::ST_DATA)
    else $error("Command byte not decoded.");
  chk_unused_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_en && addr_q == 7'h04 |=> $stable(gain_q) && $stable(ref_q) && $stable(std_b_q))
    else $error("Write to unused address changed configuration.");
  chk_type_place: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_en && addr_q == cfr_pkg::ADDR_STD_B |=> ##1 DIFF_STD[5:4] == $past(rx_byte[3:2], 2))
    else $error("Bank B output two field misplaced.");

  cov_write_burst: cover property (@(posedge MCLK) wr_en ##[1:400] wr_en);
  cov_read: cover property (@(posedge MCLK) load_q && rw_q);
  cov_lsb_mode: cover property (@(posedge MCLK) cs_start && sck_s2);

endmodule // cfr_regs
`default_nettype wire

// ===== bench/cfr_host.sv
// Serial host model that drives the configuration bank's port one whole frame at a time.
`timescale 1ns/1ns
`default_nettype none
module cfr_host (
  // Clock
  input  wire logic MCLK,
  // Serial port pins
  input  wire logic SO,
  output logic      SCK,
  output logic      CS_N,
  output logic      SI
);
  // Serial half period in MCLK cycles; the bench raises it to act as a slow host.
  int half = 8;

  // The host only ever speaks through the serial port; its pins start idle with select high.
  initial begin
    SCK  = 1'b0;
    CS_N = 1'b1;
    SI   = 1'b0;
  end

  // The clock level set before select picks the bit order, and the clock returns to it at the end.
  task automatic xfer(input bit lsb, input int n, input logic [7:0] tx [20], output logic [7:0] rx [20]);
    int idx;
    @(posedge MCLK);
    SCK <= lsb;
    repeat (4) @(posedge MCLK);
    CS_N <= 1'b0;
    repeat (half) @(posedge MCLK);
    for (int i = 0; i < n; i++) begin
      for (int b = 0; b < 8; b++) begin
        idx = lsb ? b : 7 - b;
        SCK <= 1'b0;
        SI  <= tx[i][idx];
        repeat (half) @(posedge MCLK);
        rx[i][idx] = SO;
        SCK <= 1'b1;
        repeat (half) @(posedge MCLK);
      end
    end
    SCK <= lsb;
    repeat (half) @(posedge MCLK);
    CS_N <= 1'b1;
    // A released data line must not keep showing its last bit.
    SI   <= ~SI;
    repeat (6) @(posedge MCLK);
  endtask
endmodule // cfr_host
`default_nettype wire

// ===== bench/clock_fanout_config_regs_bench.sv
// Self-checking bench for the clock fanout configuration bank, driven through its serial port.
`timescale 1ns/1ns
`default_nettype none
module clock_fanout_config_regs_bench;
  localparam int LIMIT = 40000;
  // Arbitrary part code, chosen so that every bit of the identity field shows.
  localparam logic [4:0] ID_CODE = 5'h15;
  localparam logic [47:0] RST_OUTS = {4'hf, 6'h02, 8'h40, 1'b0, 2'h0, 10'h3ff, 5'h00, 5'h00, 4'h1, 3'b000};
  localparam logic [47:0] WR_OUTS  = {4'h4, 6'h00, 8'h01, 1'b1, 2'h1, 10'h066, 5'h1f, 5'h00, 4'h6, 3'b011};

  logic            MCLK = 1'b0;
  logic            RST_N = 1'b0;
  wire logic       SCK, CS_N, SI, SO, SO_OE, XTAL_AMP_ON, SE_ON, SE_IDLE_LOW, SE_DRIVE_HIGH;
  wire logic [3:0] XTAL_GAIN_STAGES, SE_DIV_RATIO;
  wire logic [5:0] XTAL_DAMP_SEL;
  wire logic [7:0] XTAL_CAP_SEL;
  wire logic [1:0] REF_SEL;
  wire logic [9:0] DIFF_STD;
  wire logic [4:0] DIFF_ON, DIFF_IDLE_LOW;
  wire logic [47:0] outs = {XTAL_GAIN_STAGES, XTAL_DAMP_SEL, XTAL_CAP_SEL, XTAL_AMP_ON, REF_SEL, DIFF_STD,
                            DIFF_ON, DIFF_IDLE_LOW, SE_DIV_RATIO, SE_ON, SE_IDLE_LOW, SE_DRIVE_HIGH};
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] tx [20];
  logic [7:0] rx [20];
  logic [7:0] rst_img [18] = '{8'hff, 8'h04, 8'h40, 8'hff, 8'h00, 8'hfc, 8'hfe, 8'hf0, 8'h00, 8'hfc,
                               8'h00, 8'hf8, 8'hfe, 8'hfe, 8'h00, 8'h00, 8'h00, {3'b011, ID_CODE}};
  logic [7:0] wr_img [14] = '{8'h36, 8'h81, 8'h01, 8'h00, 8'hff, 8'h01, 8'h01, 8'h6f, 8'hff, 8'h1b,
                              8'hff, 8'h05, 8'h00, 8'h01};
  logic [7:0] rb_img [14] = '{8'h36, 8'h81, 8'h01, 8'hfe, 8'h00, 8'hfd, 8'hff, 8'h60, 8'h00, 8'h18,
                              8'h00, 8'hfd, 8'hfe, 8'hff};

  always #25 MCLK = ~MCLK;

  cfr_regs #(.PART_ID(ID_CODE)) uut (
    .MCLK(MCLK), .RST_N(RST_N), .SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO), .SO_OE(SO_OE),
    .XTAL_GAIN_STAGES(XTAL_GAIN_STAGES), .XTAL_DAMP_SEL(XTAL_DAMP_SEL), .XTAL_CAP_SEL(XTAL_CAP_SEL),
    .XTAL_AMP_ON(XTAL_AMP_ON), .REF_SEL(REF_SEL), .DIFF_STD(DIFF_STD), .DIFF_ON(DIFF_ON),
    .DIFF_IDLE_LOW(DIFF_IDLE_LOW), .SE_DIV_RATIO(SE_DIV_RATIO), .SE_ON(SE_ON), .SE_IDLE_LOW(SE_IDLE_LOW),
    .SE_DRIVE_HIGH(SE_DRIVE_HIGH)
  );

  cfr_host host (.MCLK(MCLK), .SO(SO), .SCK(SCK), .CS_N(CS_N), .SI(SI));

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One frame: command byte, then n data bytes taken from tx[1..n].
  task automatic frame(input bit lsb, input bit rd, input logic [6:0] addr, input int n);
    tx[0] = {rd, addr};
    host.xfer(lsb, n + 1, tx, rx);
    check("read enable idle", SO_OE, 1'b0);
  endtask

  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      results();
    end
  end

  initial begin
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    check("outputs after reset", outs, RST_OUTS);
    frame(1'b0, 1'b1, 7'h00, 18);
    for (int i = 0; i < 18; i++) begin
      check("reset image", rx[i + 1], rst_img[i]);
    end
    $display("test reset image done");

    for (int i = 0; i < 14; i++) begin
      tx[i + 1] = wr_img[i];
    end
    frame(1'b0, 1'b0, 7'h00, 14);
    check("outputs after burst write", outs, WR_OUTS);
    frame(1'b1, 1'b1, 7'h00, 14);
    for (int i = 0; i < 14; i++) begin
      check("burst read back", rx[i + 1], rb_img[i]);
    end
    $display("test burst write and read done");

    host.half = 16;
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        tx[1] = {7'h00, p[0]};
        tx[2] = 8'h00;
        tx[3] = {6'h00, c[1:0]};
        frame(c[0], 1'b0, 7'h03, 3);
        check("reference select", REF_SEL, c[1:0]);
        check("amplifier running", XTAL_AMP_ON, (c == 2) || (p == 0));
      end
    end
    host.half = 8;
    $display("test reference and run policy done");

    tx[1] = 8'h01;
    tx[2] = 8'hff;
    tx[3] = 8'h00;
    tx[4] = 8'hff;
    frame(1'b0, 1'b0, 7'h06, 4);
    check("outputs on", DIFF_ON, 5'h00);
    check("disabled pulled low", DIFF_IDLE_LOW, 5'h1f);
    check("output types", DIFF_STD, 10'h3ff);
    tx[1] = 8'hc0;
    tx[2] = 8'h7e;
    tx[3] = 8'h80;
    frame(1'b1, 1'b0, 7'h00, 3);
    check("gain stages", XTAL_GAIN_STAGES, 4'h8);
    check("damping", XTAL_DAMP_SEL, 6'h3f);
    check("load capacitors", XTAL_CAP_SEL, 8'h80);
    tx[1] = 8'h07;
    tx[2] = 8'h01;
    tx[3] = 8'h00;
    frame(1'b0, 1'b0, 7'h0b, 3);
    check("divider ratio", SE_DIV_RATIO, 4'h8);
    check("single-ended controls", {SE_ON, SE_IDLE_LOW, SE_DRIVE_HIGH}, 3'b100);
    tx[1] = 8'h00;
    frame(1'b1, 1'b0, 7'h0c, 1);
    check("single-ended idle low", {SE_ON, SE_IDLE_LOW}, 2'b01);
    frame(1'b0, 1'b0, 7'h06, 1);
    check("idle levels released", {DIFF_IDLE_LOW, SE_IDLE_LOW}, 6'h00);
    $display("test output controls done");

    frame(1'b0, 1'b0, 7'h11, 1);
    frame(1'b0, 1'b1, 7'h7f, 2);
    check("wrapped burst read", {rx[1], rx[2]}, 16'h00c0);
    frame(1'b1, 1'b1, 7'h11, 1);
    check("identity byte", rx[1], {3'b011, ID_CODE});
    $display("test identity and wrap done");
    results();
  end
endmodule // clock_fanout_config_regs_bench
`default_nettype wire
